//--- slt_cfg_regs.sv
// serial link transmit configuration bank behind a classic wishbone slave
// holds the software words and hands decoded settings to the transmitter
// assumes a single clock, synchronous active-high reset, 32-bit bus
// assumes the master drops cyc and stb for a cycle between transfers
//
// How it works
// R01: extra driver current equals pre-emphasis field times a quarter milliamp.
// R02: a zero pre-emphasis field turns pre-emphasis off entirely.
// R03: regulator boost bit selects default or raised link PLL supply.
// R04: upper byte of identifier word is the forced device identifier.
// R05: low five bits of identifier word give the forced bank identifier.
// R06: scrambler enable bit scrambles transmitted data; clear sends it plain.
// R07: with override set, frames per multiframe is stored field plus one.
// R08: subclass 000/001/010 map to 0/1/2; version 000/001 map A/B.
// R09: software writes zero to reserved bits; all reset zero, read back.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "slt_defines.svh"

module slt_cfg_regs
  import slt_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`SLT_ADR_W-1:0] wb_adr_i,
  input wire logic [`SLT_SEL_W-1:0] wb_sel_i,
  input wire logic [`SLT_DAT_W-1:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [`SLT_DAT_W-1:0] wb_dat_o,
  // configuration towards the transmitter
  output slt_link_cfg_t link_cfg_o
);

  // register map; byte address is four times the index, the register sits
  // in the low 16 bits of the word and bits 31:16 read as zero
  //   0x134 pre-emphasis
  //         bits 7:4 drive boost level, a quarter milliamp per count
  //   0x140 regulator
  //         bit 1 raises the supply of the link pll
  //   0x144 identifiers
  //         bits 15:8 forced device identifier
  //         bits 4:0 forced bank identifier
  //   0x148 scrambler
  //         bit 7 scrambles the transmitted data
  //   0x14c frame length
  //         bits 4:0 frames per multiframe minus one
  //   0x154 link mode
  //         bits 15:13 subclass, bits 7:5 version
  //   0x158 frame length control
  //         bit 0 applies the frame length, else 32 frames
  //   0x15c status, read only
  //         bit 0 bad subclass, bit 1 bad version
  //         bit 2 override active, bit 3 pre-emphasis active
  // other bits of a writable word are stored and read back as written;
  // unmapped addresses are acknowledged, read zero and drop writes

  // whole module state
  // ack, staged read data and settings all sit in flops
  typedef struct packed {
    logic ack;
    logic [`SLT_DAT_W-1:0] rdat;
    slt_link_cfg_t cfg;
  } slt_top_state_t;

  slt_top_state_t st_r;
  slt_top_state_t st_nxt;

  slt_wb_req_t req;
  logic [`SLT_IDX_W-1:0] req_idx;
  logic commit_wr;
  logic [`SLT_REG_W-1:0] words [`SLT_NUM_RW];
  logic [`SLT_REG_W-1:0] status_word;
  logic [`SLT_REG_W-1:0] rd_word;
  slt_link_cfg_t cfg_calc;
  logic req_take;

  // raw fields pulled out of the stored words
  logic [3:0] fld_boost;
  logic fld_pll_boost;
  logic [7:0] fld_dev_id;
  logic [4:0] fld_link_bank_identifier;
  logic fld_scram;
  logic [4:0] fld_kval;
  logic fld_kforce;
  logic [2:0] fld_sub;
  logic [2:0] fld_ver;

  // decoded link mode with its validity flags
  slt_subclass_t sub_sel;
  logic sub_ok;
  slt_version_t ver_sel;
  logic ver_ok;

  // gather the bus inputs into one request word
  always_comb begin
    req.cyc = wb_cyc_i;
    req.stb = wb_stb_i;
    req.we = wb_we_i;
    req.adr = wb_adr_i;
    req.sel = wb_sel_i;
    req.dat = wb_dat_i;
  end

  // word index; the two byte-offset bits are ignored
  assign req_idx = req.adr[`SLT_ADR_W-1:2];

  // a request is taken where cyc and stb stand and no ack is out yet
  assign req_take = req.cyc && req.stb && !st_r.ack;

  // a write lands only at the edge where the master sees ack high;
  // committing earlier would let a master that aborts still change a word
  assign commit_wr = req.cyc && req.stb && req.we && st_r.ack;

  // index of each storage slot
  // fixed at elaboration; each slot compares against one index
  function automatic logic [`SLT_IDX_W-1:0] slot_index(input int slot);
    logic [`SLT_IDX_W-1:0] idx;
    idx = `SLT_IDX_PREEMPH;
    case (slot)
      `SLT_SLOT_PREEMPH: idx = `SLT_IDX_PREEMPH;
      `SLT_SLOT_PLLREG: idx = `SLT_IDX_PLLREG;
      `SLT_SLOT_IDFORCE: idx = `SLT_IDX_IDFORCE;
      `SLT_SLOT_SCRAM: idx = `SLT_IDX_SCRAM;
      `SLT_SLOT_KFORCE: idx = `SLT_IDX_KFORCE;
      `SLT_SLOT_VERSUB: idx = `SLT_IDX_VERSUB;
      `SLT_SLOT_KCTRL: idx = `SLT_IDX_KCTRL;
      default: idx = `SLT_IDX_PREEMPH;
    endcase
    return idx;
  endfunction

  // one storage word per writable register
  // status and unmapped indices have no slot, so writes to them drop
  generate
    for (genvar g = 0; g < `SLT_NUM_RW; g++) begin : g_word
      logic hit;
      assign hit = commit_wr && (req_idx == slot_index(g));
      slt_cfg_word u_word (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(hit), // R09
        .byte_en_i(req.sel[1:0]),
        .wdata_i(req.dat[`SLT_REG_W-1:0]),
        .q_o(words[g])
      );
    end
  endgenerate

  // pull each field out of its storage word
  assign fld_boost = words[`SLT_SLOT_PREEMPH][`SLT_PREEMPH_MSB:`SLT_PREEMPH_LSB];
  assign fld_pll_boost = words[`SLT_SLOT_PLLREG][`SLT_PLLBOOST_BIT];
  assign fld_dev_id = words[`SLT_SLOT_IDFORCE][`SLT_DEVID_MSB:`SLT_DEVID_LSB];
  assign fld_link_bank_identifier = words[`SLT_SLOT_IDFORCE][`SLT_BANKID_MSB:`SLT_BANKID_LSB];
  assign fld_scram = words[`SLT_SLOT_SCRAM][`SLT_SCRAM_BIT];
  assign fld_kval = words[`SLT_SLOT_KFORCE][`SLT_KVAL_MSB:`SLT_KVAL_LSB];
  assign fld_kforce = words[`SLT_SLOT_KCTRL][`SLT_KCTRL_BIT];
  assign fld_sub = words[`SLT_SLOT_VERSUB][`SLT_SUB_MSB:`SLT_SUB_LSB];
  assign fld_ver = words[`SLT_SLOT_VERSUB][`SLT_VER_MSB:`SLT_VER_LSB];

  // subclass decode; undefined codes are flagged and passed on as subclass 0
  // so the transmitter never sees a code it cannot handle
  always_comb begin
    sub_sel = SLT_SUBCLASS_0;
    sub_ok = 1'b0;
    case (fld_sub)
      3'h0: begin
        sub_sel = SLT_SUBCLASS_0; // R08
        sub_ok = 1'b1;
      end
      3'h1: begin
        sub_sel = SLT_SUBCLASS_1; // R08
        sub_ok = 1'b1;
      end
      3'h2: begin
        sub_sel = SLT_SUBCLASS_2; // R08
        sub_ok = 1'b1;
      end
      default: begin
        sub_sel = SLT_SUBCLASS_0;
        sub_ok = 1'b0;
      end
    endcase
  end

  // version decode; undefined codes are flagged and passed on as version A
  always_comb begin
    ver_sel = SLT_VERSION_A;
    ver_ok = 1'b0;
    case (fld_ver)
      3'h0: begin
        ver_sel = SLT_VERSION_A; // R08
        ver_ok = 1'b1;
      end
      3'h1: begin
        ver_sel = SLT_VERSION_B; // R08
        ver_ok = 1'b1;
      end
      default: begin
        ver_sel = SLT_VERSION_A;
        ver_ok = 1'b0;
      end
    endcase
  end

  // assemble the settings handed to the transmitter
  always_comb begin
    cfg_calc = '0;
    cfg_calc.drive_boost_level = fld_boost;
    // extra current in microamps, 250 per count; 15 counts still fit in 12 bits
    cfg_calc.drive_extra_current_ua = 12'({8'h00, fld_boost}) * `SLT_PREEMPH_STEP_UA; // R01
    cfg_calc.preemphasis_on = (fld_boost != 4'h0); // R02
    cfg_calc.pll_regulator_boost = fld_pll_boost; // R03
    cfg_calc.link_device_identifier = fld_dev_id; // R04
    cfg_calc.link_bank_identifier = fld_link_bank_identifier; // R05
    cfg_calc.scrambler_on = fld_scram; // R06
    cfg_calc.frames_override_on = fld_kforce;
    // the field holds the count minus one, so zero means a single frame;
    // without the override the bank drives the default length of 32 frames
    if (fld_kforce) begin
      cfg_calc.frames_per_multiframe = {1'b0, fld_kval} + 6'h01; // R07
    end else begin
      cfg_calc.frames_per_multiframe = `SLT_K_DEFAULT;
    end
    cfg_calc.link_subclass_select = sub_sel; // R08
    cfg_calc.subclass_valid = sub_ok;
    cfg_calc.link_version_select = ver_sel; // R08
    cfg_calc.version_valid = ver_ok;
  end

  // read-only status reflecting the settings being driven
  // taken from the registered settings, so it trails a write by one edge
  always_comb begin
    status_word = '0;
    status_word[`SLT_STAT_SUB_BAD] = ~st_r.cfg.subclass_valid;
    status_word[`SLT_STAT_VER_BAD] = ~st_r.cfg.version_valid;
    status_word[`SLT_STAT_K_FORCED] = st_r.cfg.frames_override_on;
    status_word[`SLT_STAT_PREEMPH_ON] = st_r.cfg.preemphasis_on;
  end

  // read multiplexer; unmapped indices read as zero
  // the index comes from the address held through the transfer
  always_comb begin
    case (req_idx)
      `SLT_IDX_PREEMPH: rd_word = words[`SLT_SLOT_PREEMPH];
      `SLT_IDX_PLLREG: rd_word = words[`SLT_SLOT_PLLREG];
      `SLT_IDX_IDFORCE: rd_word = words[`SLT_SLOT_IDFORCE];
      `SLT_IDX_SCRAM: rd_word = words[`SLT_SLOT_SCRAM];
      `SLT_IDX_KFORCE: rd_word = words[`SLT_SLOT_KFORCE];
      `SLT_IDX_VERSUB: rd_word = words[`SLT_SLOT_VERSUB];
      `SLT_IDX_KCTRL: rd_word = words[`SLT_SLOT_KCTRL];
      `SLT_IDX_STATUS: rd_word = status_word;
      default: rd_word = '0;
    endcase
  end

  // bus handshake and output staging
  always_comb begin
    st_nxt = st_r;
    // ack rises one edge after the request and falls the edge after,
    // so a master that holds its request sees one pulse per transfer
    st_nxt.ack = req_take;
    // read data captured with the rising ack, held while ack stands and for the cycle after;
    // then the data lines rest at zero until the next capture
    if (req_take) begin
      st_nxt.rdat = {16'h0000, rd_word};
    end else if (!st_r.ack) begin
      st_nxt.rdat = '0;
    end
    // settings follow the stored words one edge later
    st_nxt.cfg = cfg_calc;
  end

  // state register; reset holds the settings cleared for as long as it stands and the
  // first edge after release loads the decoded defaults
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  // settings change only at edges, so the driver side sees no glitches
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdat;
  assign link_cfg_o = st_r.cfg;

endmodule
`default_nettype wire

//--- slt_defines.svh
// register offsets, field positions, reset values and fixed constants of the
// serial link transmit configuration bank; assumes inclusion by bare name
`ifndef SLT_DEFINES_SVH
`define SLT_DEFINES_SVH

// wishbone geometry: byte address, one 32-bit word per register index
`define SLT_ADR_W 10
`define SLT_DAT_W 32
`define SLT_SEL_W 4
`define SLT_REG_W 16
`define SLT_IDX_W 8

// register indices (byte address is four times the index)
`define SLT_IDX_PREEMPH 8'h4d
`define SLT_IDX_PLLREG 8'h50
`define SLT_IDX_IDFORCE 8'h51
`define SLT_IDX_SCRAM 8'h52
`define SLT_IDX_KFORCE 8'h53
`define SLT_IDX_VERSUB 8'h55
`define SLT_IDX_KCTRL 8'h56
`define SLT_IDX_STATUS 8'h57

// number of software-writable words and their common reset value
`define SLT_NUM_RW 7
`define SLT_REG_RESET 16'h0000

// word slots inside the storage array
`define SLT_SLOT_PREEMPH 0
`define SLT_SLOT_PLLREG 1
`define SLT_SLOT_IDFORCE 2
`define SLT_SLOT_SCRAM 3
`define SLT_SLOT_KFORCE 4
`define SLT_SLOT_VERSUB 5
`define SLT_SLOT_KCTRL 6

// field positions
`define SLT_PREEMPH_MSB 7
`define SLT_PREEMPH_LSB 4
`define SLT_PLLBOOST_BIT 1
`define SLT_DEVID_MSB 15
`define SLT_DEVID_LSB 8
`define SLT_BANKID_MSB 4
`define SLT_BANKID_LSB 0
`define SLT_SCRAM_BIT 7
`define SLT_KVAL_MSB 4
`define SLT_KVAL_LSB 0
`define SLT_KCTRL_BIT 0
`define SLT_SUB_MSB 15
`define SLT_SUB_LSB 13
`define SLT_VER_MSB 7
`define SLT_VER_LSB 5

// status word bit positions
`define SLT_STAT_SUB_BAD 0
`define SLT_STAT_VER_BAD 1
`define SLT_STAT_K_FORCED 2
`define SLT_STAT_PREEMPH_ON 3

// pre-emphasis step of a quarter milliamp, in microamps
`define SLT_PREEMPH_STEP_UA 12'd250
// frames per multiframe used while no override is requested
`define SLT_K_DEFAULT 6'd32

`endif

//--- slt_pkg.sv
// types shared by the serial link transmit configuration bank
// assumes slt_defines.svh is on the include path
`default_nettype none
`include "slt_defines.svh"

package slt_pkg;

  // link subclass codes
  typedef enum logic [2:0] {
    SLT_SUBCLASS_0 = 3'h0,
    SLT_SUBCLASS_1 = 3'h1,
    SLT_SUBCLASS_2 = 3'h2
  } slt_subclass_t;

  // link version codes
  typedef enum logic [2:0] {
    SLT_VERSION_A = 3'h0,
    SLT_VERSION_B = 3'h1
  } slt_version_t;

  // classic wishbone request as seen by the slave
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [`SLT_ADR_W-1:0] adr;
    logic [`SLT_SEL_W-1:0] sel;
    logic [`SLT_DAT_W-1:0] dat;
  } slt_wb_req_t;

  // configuration handed to the transmitter and its analog drivers
  typedef struct packed {
    logic [3:0] drive_boost_level;
    logic [11:0] drive_extra_current_ua;
    logic preemphasis_on;
    logic pll_regulator_boost;
    logic [7:0] link_device_identifier;
    logic [4:0] link_bank_identifier;
    logic scrambler_on;
    logic frames_override_on;
    logic [5:0] frames_per_multiframe;
    slt_subclass_t link_subclass_select;
    logic subclass_valid;
    slt_version_t link_version_select;
    logic version_valid;
  } slt_link_cfg_t;

  // one storage word
  typedef struct packed {
    logic [`SLT_REG_W-1:0] word;
  } slt_word_state_t;

endpackage
`default_nettype wire

//--- slt_cfg_word.sv
// one 16-bit software configuration word with two byte lanes
// assumes the caller commits writes only at the acknowledging edge
`timescale 1ns/1ps
`default_nettype none
`include "slt_defines.svh"

module slt_cfg_word
  import slt_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [1:0] byte_en_i,
  input wire logic [`SLT_REG_W-1:0] wdata_i,
  // stored value
  output logic [`SLT_REG_W-1:0] q_o
);

  slt_word_state_t st_r;
  slt_word_state_t st_nxt;

  // every bit, reserved ones too, keeps what was last written
  always_comb begin
    st_nxt = st_r;
    if (wr_en_i && byte_en_i[0]) begin
      st_nxt.word[7:0] = wdata_i[7:0];
    end
    if (wr_en_i && byte_en_i[1]) begin
      st_nxt.word[15:8] = wdata_i[15:8];
    end
  end

  // state register, cleared by reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '{word: `SLT_REG_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.word;

endmodule
`default_nettype wire

//--- slt_rx_model.sv
// link receiver model: takes the transmit configuration the way the far lane end would
// assumes one clock shared with the register bank
`timescale 1ns/1ps
`default_nettype none

module slt_rx_model
  import slt_pkg::*;
(
  // clock
  input wire logic clk_i,
  // configuration seen across the link
  input wire slt_link_cfg_t cfg_i,
  // frames per multiframe the receiver aligns to
  output logic [5:0] k_o
);
  // latch the multiframe length once a clock, as the receiver's aligner would
  always_ff @(posedge clk_i) begin
    k_o <= cfg_i.frames_per_multiframe;
  end
endmodule

`default_nettype wire

//--- slt_cfg_regs_chk.sv
// checker for the transmit configuration bank, bound to its ports
// assumes a write lands on the outputs two cycles after its acknowledge
`timescale 1ns/1ps
`default_nettype none

module slt_cfg_regs_chk
  import slt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire slt_link_cfg_t link_cfg_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic w1;
  logic w2;
  logic [9:0] wa;
  logic [3:0] ws;
  logic [15:0] wd;
  // remember the last acknowledged transfer and mark when a write reaches the outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      w1 <= 1'b0;
      w2 <= 1'b0;
    end else begin
      w1 <= wb_ack_o & wb_we_i;
      w2 <= w1;
    end
    if (wb_ack_o) begin
      wa <= wb_adr_i;
      ws <= wb_sel_i;
      wd <= wb_dat_i[15:0];
    end
  end
  chk_extra_current: assert property (link_cfg_o.drive_extra_current_ua == link_cfg_o.drive_boost_level * 12'd250)
    else $error("extra drive current wrong");
  chk_preemph_off: assert property (link_cfg_o.preemphasis_on == (link_cfg_o.drive_boost_level != 4'h0))
    else $error("pre-emphasis enable wrong");
  chk_pll_boost: assert property (w2 && wa == 10'h140 && ws[0] |-> link_cfg_o.pll_regulator_boost == wd[1])
    else $error("regulator boost wrong");
  chk_link_device_identifier: assert property (w2 && wa == 10'h144 && ws[1] |-> link_cfg_o.link_device_identifier == wd[15:8])
    else $error("device identifier wrong");
  chk_link_bank_identifier: assert property (w2 && wa == 10'h144 && ws[0] |-> link_cfg_o.link_bank_identifier == wd[4:0])
    else $error("bank identifier wrong");
  chk_scrambler_bit: assert property (w2 && wa == 10'h148 && ws[0] |-> link_cfg_o.scrambler_on == wd[7])
    else $error("scrambler enable wrong");
  chk_frames_len: assert property (w2 && wa == 10'h14c && ws[0] && link_cfg_o.frames_override_on
    |-> link_cfg_o.frames_per_multiframe == {1'b0, wd[4:0]} + 6'h01)
    else $error("frames per multiframe wrong");
  chk_subclass_code: assert property (w2 && wa == 10'h154 && ws[1] && wd[15:13] < 3'h3
    |-> link_cfg_o.subclass_valid && link_cfg_o.link_subclass_select == wd[15:13])
    else $error("subclass decode wrong");
  chk_version_code: assert property (w2 && wa == 10'h154 && ws[0] && wd[7:5] < 3'h2
    |-> link_cfg_o.version_valid && link_cfg_o.link_version_select == wd[7:5])
    else $error("version decode wrong");
  cover property (w2 && wa == 10'h14c);
  cover property (link_cfg_o.scrambler_on);
  cover property (wb_ack_o && !wb_we_i);
endmodule

bind slt_cfg_regs slt_cfg_regs_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .link_cfg_o(link_cfg_o));

`default_nettype wire

//--- slt_cfg_regs_bench.sv
// self-checking bench for the transmit configuration bank over classic wishbone
// assumes the acknowledge comes within a few cycles of each request
`timescale 1ns/1ps
`default_nettype none

module slt_cfg_regs_bench;
  import slt_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  slt_link_cfg_t link_cfg_o;
  logic [5:0] rx_k;
  int n_mismatch = 0;
  int comparisons = 0;
  int seed = 32'h0cc2;
  logic [31:0] exp_q[$];
  logic [15:0] v;
  logic [15:0] vals[6];
  logic [9:0] adrs[6] = '{10'h134, 10'h140, 10'h144, 10'h148, 10'h14c, 10'h154};
  logic [15:0] msk[6] = '{16'h00f0, 16'h0002, 16'hff1f, 16'h0080, 16'h001f, 16'he0e0};

  always #10 clk_i = ~clk_i;

  slt_cfg_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .link_cfg_o(link_cfg_o));
  slt_rx_model rx (.clk_i(clk_i), .cfg_i(link_cfg_o), .k_o(rx_k));

  // compare and count
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task end_of_test;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [9:0] a, input logic [3:0] s, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_mismatch++;
      end_of_test;
    end else begin
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask

  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    exp_q.push_back({16'h0, e});
    bus(1'b0, a, 4'hf, 32'h0);
  endtask

  // write, then let the configuration settle
  task automatic wc(input logic [9:0] a, input logic [15:0] d);
    bus(1'b1, a, 4'h3, {16'h0, d});
    repeat (2) @(posedge clk_i);
  endtask

  // read data monitor against the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) cmp(wb_dat_o, 32'hffffffff);
      else cmp(wb_dat_o, exp_q.pop_front());
    end
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (adrs[k]) rd(adrs[k], 16'h0);
    foreach (adrs[k]) begin
      v = 16'($random(seed)) & msk[k];
      vals[k] = v;
      wc(adrs[k], v);
      rd(adrs[k], v);
    end
    bus(1'b1, 10'h144, 4'h1, 32'h0000ab00);
    rd(10'h144, vals[2] & 16'hff00);
    cmp(link_cfg_o.link_device_identifier, vals[2][15:8]);
    cmp(link_cfg_o.link_bank_identifier, 0);
    rd(10'h200, 16'h0);
    for (int n = 0; n < 16; n++) begin
      wc(10'h134, 16'(n << 4));
      cmp(link_cfg_o.drive_extra_current_ua, n * 250);
      cmp(link_cfg_o.preemphasis_on, n != 0);
    end
    cmp(link_cfg_o.frames_per_multiframe, 32);
    wc(10'h158, 16'h0001);
    rd(10'h158, 16'h0001);
    for (int n = 0; n < 32; n += 31) begin
      wc(10'h14c, 16'(n));
      cmp(link_cfg_o.frames_per_multiframe, n + 1);
      @(posedge clk_i);
      cmp(rx_k, n + 1);
    end
    for (int n = 0; n < 3; n++) begin
      wc(10'h154, 16'((n << 13) | ((n & 1) << 5)));
      cmp(link_cfg_o.link_subclass_select, n);
      cmp(link_cfg_o.link_version_select, n & 1);
    end
    wc(10'h154, 16'he0e0);
    cmp({link_cfg_o.subclass_valid, link_cfg_o.version_valid}, 0);
    rd(10'h15c, 16'h000f);
    wc(10'h140, 16'h0002);
    cmp(link_cfg_o.pll_regulator_boost, 1);
    wc(10'h148, 16'h0080);
    cmp(link_cfg_o.scrambler_on, 1);
    end_of_test;
  end
endmodule

`default_nettype wire
